/* logic/sgoc_pkg.sv */
// Package: settings, states and register map of the object control block
package sgoc_pkg;
    // Object types
    typedef enum logic [1:0] {
        SGOC_OBJ_WITHDRAWABLE = 2'h0,
        SGOC_OBJ_BREAKER = 2'h1,
        SGOC_OBJ_DISC_MC = 2'h2,
        SGOC_OBJ_DISC_GND = 2'h3
    } sgoc_obj_type;
    // Breaker position
    typedef enum logic [1:0] {
        SGOC_POS_MID = 2'h0,
        SGOC_POS_OPEN = 2'h1,
        SGOC_POS_CLOSED = 2'h2,
        SGOC_POS_BAD = 2'h3
    } sgoc_pos_type;
    // Cart position
    typedef enum logic [2:0] {
        SGOC_CART_MIDWAY = 3'h0,
        SGOC_CART_OUT = 3'h1,
        SGOC_CART_IN = 3'h2,
        SGOC_CART_CONFLICT = 3'h3,
        SGOC_CART_UNUSED = 3'h4
    } sgoc_cart_type;
    // Block modes
    typedef enum logic [2:0] {
        SGOC_MODE_ON = 3'h0,
        SGOC_MODE_BLOCKED = 3'h1,
        SGOC_MODE_TEST = 3'h2,
        SGOC_MODE_TEST_BLOCKED = 3'h3,
        SGOC_MODE_OFF = 3'h4
    } sgoc_mode_type;
    // Ready gating choice
    localparam logic [1:0] SGOC_RDY_UNUSED = 2'h0;
    localparam logic [1:0] SGOC_RDY_HIGH = 2'h1;
    localparam logic [1:0] SGOC_RDY_LOW = 2'h2;
    // Force selector codes
    localparam logic [3:0] SGOC_FORCE_NORMAL = 4'h0;
    localparam int SGOC_FORCE_COUNT = 13;
    localparam int SGOC_STAT_W = 12;
    // Status bit positions
    localparam int SGOC_ST_OPEN_REQ = 0;
    localparam int SGOC_ST_CLOSE_REQ = 1;
    localparam int SGOC_ST_OPEN_SIG = 2;
    localparam int SGOC_ST_CLOSE_SIG = 3;
    localparam int SGOC_ST_WAIT_RDY = 4;
    localparam int SGOC_ST_WAIT_SNC = 5;
    localparam int SGOC_ST_RDY_FAIL = 6;
    localparam int SGOC_ST_SNC_FAIL = 7;
    localparam int SGOC_ST_OPEN_TOUT = 8;
    localparam int SGOC_ST_CLOSE_TOUT = 9;
    localparam int SGOC_ST_USR_OPEN = 10;
    localparam int SGOC_ST_USR_CLOSE = 11;
    // Register byte offsets
    localparam logic [7:0] SGOC_REG_CTRL = 8'h00;
    localparam logic [7:0] SGOC_REG_CONFIG = 8'h04;
    localparam logic [7:0] SGOC_REG_CMD = 8'h08;
    localparam logic [7:0] SGOC_REG_STATUS = 8'h0c;
    localparam logic [7:0] SGOC_REG_NAME = 8'h10;
    localparam int SGOC_NAME_WORDS = 8;
    localparam logic [7:0] SGOC_REG_END = 8'h30;
    // Command register bits
    localparam int SGOC_CMD_OPEN = 0;
    localparam int SGOC_CMD_CLOSE = 1;
    localparam int SGOC_CMD_SELECT = 2;
    localparam int SGOC_CMD_CANCEL = 3;
    // Config field positions
    localparam int SGOC_CFG_TYPE = 0;
    localparam int SGOC_CFG_SYNC = 2;
    localparam int SGOC_CFG_RDY = 3;
    localparam int SGOC_CFG_SBO = 5;
    localparam int SGOC_CFG_SINGLE = 6;
    localparam int SGOC_CFG_MODE = 8;
    localparam int SGOC_CFG_FORCE = 12;
    localparam logic [31:0] SGOC_CFG_RESET = 32'h00000001;
    // Ctrl bits
    localparam int SGOC_CTRL_LOCAL = 0;
    localparam int SGOC_CTRL_FORCE_EN = 1;
    localparam int SGOC_CTRL_MODE_EN = 2;
    // Command pulse width
    localparam int SGOC_PULSE_NS = 100;
    localparam int SGOC_CLK_MHZ = 200;
    localparam int SGOC_PULSE_CYC = (SGOC_PULSE_NS * SGOC_CLK_MHZ + 999) / 1000;
endpackage

/* logic/sgoc_cmd_if.sv */
// Interface: arbitrated command requests into the output stage
`timescale 1ns/1ps
`default_nettype none
interface sgoc_cmd_if;
    logic open_req;
    logic close_req;
    logic busy;
    logic open_act;
    logic close_act;
    modport src (output open_req, output close_req, input busy, input open_act, input close_act);
    modport drv (input open_req, input close_req, output busy, output open_act, output close_act);
endinterface
`default_nettype wire

/* logic/sgoc_out_stage.sv */
// Output stage: exclusive open and close command pulses
`timescale 1ns/1ps
`default_nettype none
module sgoc_out_stage
    import sgoc_pkg::*;
#(
    parameter int PULSE_CYC = SGOC_PULSE_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Requests
    sgoc_cmd_if.drv cmd
);
    logic [7:0] cnt_q;
    logic open_q;
    logic close_q;
    assign cmd.busy = open_q | close_q;
    assign cmd.open_act = open_q;
    assign cmd.close_act = close_q;
    // A request during a running pulse is the later one and is dropped
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            open_q <= 1'b0;
            close_q <= 1'b0;
            cnt_q <= 8'h00;
        end else if (cmd.busy) begin
            if (cnt_q == 8'h01) begin
                open_q <= 1'b0;
                close_q <= 1'b0;
            end
            cnt_q <= cnt_q - 8'h01;
        end else if (cmd.open_req) begin
            open_q <= 1'b1;
            cnt_q <= PULSE_CYC[7:0];
        end else if (cmd.close_req) begin
            close_q <= 1'b1;
            cnt_q <= PULSE_CYC[7:0];
        end
    end
endmodule
`default_nettype wire

/* logic/sgoc_top.sv */
// Switchgear object control: decode, arbitration, gating and APB registers
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module sgoc_top
    import sgoc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Object status pins
    input wire logic open_stat_in,
    input wire logic close_stat_in,
    input wire logic cart_in_stat_in,
    input wire logic cart_out_stat_in,
    input wire logic ready_stat_in,
    input wire logic sync_stat_in,
    // Local command sources
    input wire logic button_open_in,
    input wire logic button_close_in,
    input wire logic front_panel_open_in,
    input wire logic front_panel_close_in,
    // Automatic function commands
    input wire logic auto_open_in,
    input wire logic auto_close_in,
    // Command contacts
    output logic object_open_out,
    output logic object_close_out,
    // Status view
    output logic [1:0] breaker_state_out,
    output logic [2:0] cart_state_out,
    output logic [2:0] object_block_behaviour_view_out,
    output logic [SGOC_STAT_W-1:0] status_out
);
    // Two-flop synchronisers for all status and command pins
    localparam int NPIN = 10;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_m_q;
    logic [NPIN-1:0] pin_q;
    assign pin_raw = {auto_close_in, auto_open_in, front_panel_close_in, front_panel_open_in,
                      button_close_in, button_open_in, sync_stat_in, ready_stat_in,
                      cart_out_stat_in, cart_in_stat_in};
    logic open_raw_q;
    logic close_raw_q;
    logic open_s_q;
    logic close_s_q;
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pin_m_q <= '0;
            pin_q <= '0;
            open_raw_q <= 1'b0;
            close_raw_q <= 1'b0;
            open_s_q <= 1'b0;
            close_s_q <= 1'b0;
        end else begin
            pin_m_q <= pin_raw;
            pin_q <= pin_m_q;
            open_raw_q <= open_stat_in;
            close_raw_q <= close_stat_in;
            open_s_q <= open_raw_q;
            close_s_q <= close_raw_q;
        end
    end
    logic cart_in_s, cart_out_s, ready_s, sync_s;
    logic btn_open_s, btn_close_s, fp_open_s, fp_close_s, auto_open_s, auto_close_s;
    assign {auto_close_s, auto_open_s, fp_close_s, fp_open_s, btn_close_s, btn_open_s,
            sync_s, ready_s, cart_out_s, cart_in_s} = pin_q;

    // Registers
    logic [31:0] ctrl_q;
    logic [31:0] cfg_q;
    logic [31:0] name_q [SGOC_NAME_WORDS];
    logic sel_q;
    logic rem_open_q;
    logic rem_close_q;
    logic [SGOC_STAT_W-1:0] stat_q;

    function automatic logic [1:0] pair_decode(input logic a, input logic b);
        // a marks the first state, b the second
        return {b, a};
    endfunction

    sgoc_obj_type obj_type;
    sgoc_mode_type mode;
    logic is_local, force_en, mode_en, use_sync, use_single, sbo_mode;
    logic [1:0] rdy_mode;
    logic [3:0] force_sel;
    assign is_local = ctrl_q[SGOC_CTRL_LOCAL];
    assign force_en = ctrl_q[SGOC_CTRL_FORCE_EN];
    assign mode_en = ctrl_q[SGOC_CTRL_MODE_EN];
    // Static settings, sampled by logic only as levels
    assign obj_type = sgoc_obj_type'(cfg_q[SGOC_CFG_TYPE +: 2]);
    assign use_sync = cfg_q[SGOC_CFG_SYNC];
    assign rdy_mode = cfg_q[SGOC_CFG_RDY +: 2];
    assign sbo_mode = cfg_q[SGOC_CFG_SBO];
    assign use_single = cfg_q[SGOC_CFG_SINGLE];
    assign force_sel = cfg_q[SGOC_CFG_FORCE +: 4];
    assign mode = mode_en ? sgoc_mode_type'(cfg_q[SGOC_CFG_MODE +: 3]) : SGOC_MODE_ON;

    // Position decode
    logic close_eff;
    sgoc_pos_type pos;
    sgoc_cart_type cart;
    assign close_eff = use_single ? ~open_s_q : close_s_q;
    assign pos = sgoc_pos_type'(pair_decode(open_s_q, close_eff));
    always_comb begin
        if (obj_type != SGOC_OBJ_WITHDRAWABLE) begin
            cart = SGOC_CART_UNUSED;
        end else begin
            cart = sgoc_cart_type'({1'b0, pair_decode(cart_out_s, cart_in_s)});
        end
    end

    // Source arbitration
    logic wr_cmd;
    logic rem_open_ok, rem_close_ok;
    logic loc_open, loc_close;
    logic want_open, want_close;
    logic rdy_ok, close_ok, ctl_en, is_test;
    assign wr_cmd = psel_in & penable_in & pwrite_in & (paddr_in == SGOC_REG_CMD);
    assign loc_open = is_local & (btn_open_s | fp_open_s);
    assign loc_close = is_local & (btn_close_s | fp_close_s);
    assign rem_open_ok = ~is_local & rem_open_q;
    assign rem_close_ok = ~is_local & rem_close_q;
    assign ctl_en = (mode == SGOC_MODE_ON) | (mode == SGOC_MODE_TEST);
    assign is_test = (mode == SGOC_MODE_TEST) | (mode == SGOC_MODE_TEST_BLOCKED);
    // Ready and sync gating of close
    always_comb begin
        case (rdy_mode)
            SGOC_RDY_HIGH: rdy_ok = ready_s;
            SGOC_RDY_LOW: rdy_ok = ~ready_s;
            default: rdy_ok = 1'b1;
        endcase
    end
    assign close_ok = rdy_ok & (~use_sync | sync_s) & (obj_type != SGOC_OBJ_DISC_GND);
    assign want_open = (loc_open | rem_open_ok | auto_open_s) & (obj_type != SGOC_OBJ_DISC_GND);
    assign want_close = loc_close | rem_close_ok | auto_close_s;

    sgoc_cmd_if cmd_bus ();
    assign cmd_bus.open_req = ctl_en & want_open;
    assign cmd_bus.close_req = ctl_en & want_close & close_ok & ~want_open;
    sgoc_out_stage #(
        .PULSE_CYC(SGOC_PULSE_CYC)
    ) u_out (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .cmd(cmd_bus)
    );
    // Test mode keeps contacts quiet while logic runs
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            object_open_out <= 1'b0;
            object_close_out <= 1'b0;
        end else begin
            object_open_out <= cmd_bus.open_act & ~is_test;
            object_close_out <= cmd_bus.close_act & ~is_test;
        end
    end

    // Remote request latch: direct, or select then execute
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sel_q <= 1'b0;
            rem_open_q <= 1'b0;
            rem_close_q <= 1'b0;
        end else begin
            rem_open_q <= 1'b0;
            rem_close_q <= 1'b0;
            if (wr_cmd) begin
                if (pwdata_in[SGOC_CMD_CANCEL]) begin
                    sel_q <= 1'b0;
                end else if (pwdata_in[SGOC_CMD_SELECT]) begin
                    sel_q <= 1'b1;
                end else if (~sbo_mode | sel_q) begin
                    rem_open_q <= pwdata_in[SGOC_CMD_OPEN];
                    rem_close_q <= pwdata_in[SGOC_CMD_CLOSE] & ~pwdata_in[SGOC_CMD_OPEN];
                    sel_q <= 1'b0;
                end
            end
        end
    end

    // Internal status, with forcing
    logic [SGOC_STAT_W-1:0] stat_d;
    always_comb begin
        stat_d = '0;
        stat_d[SGOC_ST_OPEN_REQ] = want_open;
        stat_d[SGOC_ST_CLOSE_REQ] = want_close;
        stat_d[SGOC_ST_OPEN_SIG] = cmd_bus.open_act;
        stat_d[SGOC_ST_CLOSE_SIG] = cmd_bus.close_act;
        stat_d[SGOC_ST_WAIT_RDY] = want_close & ~rdy_ok;
        stat_d[SGOC_ST_WAIT_SNC] = want_close & use_sync & ~sync_s;
        stat_d[SGOC_ST_RDY_FAIL] = cmd_bus.close_req == 1'b0 & want_close & ~rdy_ok & ctl_en;
        stat_d[SGOC_ST_SNC_FAIL] = want_close & use_sync & ~sync_s & ctl_en;
        stat_d[SGOC_ST_USR_OPEN] = loc_open | rem_open_ok;
        stat_d[SGOC_ST_USR_CLOSE] = loc_close | rem_close_ok;
        if (force_en && force_sel != SGOC_FORCE_NORMAL && force_sel < 4'(SGOC_FORCE_COUNT)) begin
            stat_d[force_sel - 4'h1] = 1'b1;
        end
    end
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            stat_q <= '0;
            breaker_state_out <= 2'h0;
            cart_state_out <= 3'h0;
            object_block_behaviour_view_out <= 3'h0;
        end else begin
            stat_q <= stat_d;
            breaker_state_out <= pos;
            cart_state_out <= cart;
            object_block_behaviour_view_out <= mode;
        end
    end
    assign status_out = stat_q;

    // APB register file, zero wait states
    logic apb_wr, addr_ok, name_hit;
    logic [2:0] name_idx;
    logic [31:0] rdata_d;
    assign apb_wr = psel_in & penable_in & pwrite_in;
    assign name_hit = (paddr_in >= SGOC_REG_NAME) && (paddr_in < SGOC_REG_END);
    assign name_idx = 3'((paddr_in - SGOC_REG_NAME) >> 2);
    assign addr_ok = (paddr_in[1:0] == 2'h0) && (paddr_in < SGOC_REG_END);
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in & penable_in & ~addr_ok;
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctrl_q <= 32'h00000000;
            cfg_q <= SGOC_CFG_RESET;
        end else if (apb_wr && addr_ok) begin
            if (paddr_in == SGOC_REG_CTRL) begin
                ctrl_q <= {29'h0, pwdata_in[2:0]};
            end
            if (paddr_in == SGOC_REG_CONFIG) begin
                cfg_q <= {16'h0, pwdata_in[15:0]};
            end
        end
    end
    // Name storage: 8 words of 4 characters
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < SGOC_NAME_WORDS; i++) begin
                name_q[i] <= 32'h00000000;
            end
        end else if (apb_wr && addr_ok && name_hit) begin
            name_q[name_idx] <= pwdata_in;
        end
    end
    always_comb begin
        rdata_d = 32'h00000000;
        if (addr_ok) begin
            if (name_hit) begin
                rdata_d = name_q[name_idx];
            end else begin
                case (paddr_in)
                    SGOC_REG_CTRL: rdata_d = ctrl_q;
                    SGOC_REG_CONFIG: rdata_d = cfg_q;
                    SGOC_REG_CMD: rdata_d = {31'h0, sel_q};
                    SGOC_REG_STATUS: rdata_d = {12'h0, mode, cart, pos, stat_q};
                    default: rdata_d = 32'h00000000;
                endcase
            end
        end
    end
    // Taken at the setup edge, so read data stands through the access phase
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            prdata_out <= 32'h00000000;
        end else if (psel_in && !penable_in) begin
            prdata_out <= rdata_d;
        end
    end
endmodule
`default_nettype wire

/* tb/sgoc_top_assertions.sv */
// Checker: port relations of the object control block
`timescale 1ns/1ps
`default_nettype none
module sgoc_top_assertions
    import sgoc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Bus
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic [7:0] paddr_in,
    input wire logic pslverr_out,
    // Object pins
    input wire logic open_stat_in,
    input wire logic close_stat_in,
    input wire logic cart_in_stat_in,
    input wire logic cart_out_stat_in,
    input wire logic object_open_out,
    input wire logic object_close_out,
    // Views
    input wire logic [1:0] breaker_state_out,
    input wire logic [2:0] cart_state_out,
    input wire logic [2:0] object_block_behaviour_view_out
);
    logic [5:0] olen_q;
    logic [5:0] clen_q;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // Length of the running contact pulses
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            olen_q <= 6'h0;
            clen_q <= 6'h0;
        end else begin
            olen_q <= object_open_out ? olen_q + 6'h1 : 6'h0;
            clen_q <= object_close_out ? clen_q + 6'h1 : 6'h0;
        end
    end
    property p_excl;
        !(object_open_out && object_close_out);
    endproperty
    property p_pos;
        (open_stat_in && !close_stat_in) [*4] |=> breaker_state_out == SGOC_POS_OPEN;
    endproperty
    property p_cart;
        (cart_in_stat_in && !cart_out_stat_in) [*4] |=> cart_state_out inside {SGOC_CART_IN, SGOC_CART_UNUSED};
    endproperty
    property p_olen;
        $fell(object_open_out) |-> olen_q == SGOC_PULSE_CYC;
    endproperty
    property p_clen;
        $fell(object_close_out) |-> clen_q == SGOC_PULSE_CYC;
    endproperty
    property p_omax;
        olen_q <= SGOC_PULSE_CYC && clen_q <= SGOC_PULSE_CYC;
    endproperty
    property p_view;
        object_block_behaviour_view_out <= 3'h4;
    endproperty
    property p_slv_bad;
        psel_in && penable_in && (paddr_in >= SGOC_REG_END || paddr_in[1:0] != 2'h0) |-> pslverr_out;
    endproperty
    property p_slv_ok;
        psel_in && penable_in && paddr_in < SGOC_REG_END && paddr_in[1:0] == 2'h0 |-> !pslverr_out;
    endproperty
    a_excl: assert property (p_excl) else $error("open and close together");
    a_pos: assert property (p_pos) else $error("open position not decoded");
    a_cart: assert property (p_cart) else $error("cart in not decoded");
    a_olen: assert property (p_olen) else $error("open pulse length wrong");
    a_clen: assert property (p_clen) else $error("close pulse length wrong");
    a_omax: assert property (p_omax) else $error("pulse too long");
    a_view: assert property (p_view) else $error("behaviour code out of range");
    a_slv_bad: assert property (p_slv_bad) else $error("bad address accepted");
    a_slv_ok: assert property (p_slv_ok) else $error("good address refused");
    c_open: cover property ($rose(object_open_out));
    c_close: cover property ($rose(object_close_out));
    c_err: cover property (psel_in && penable_in && pslverr_out);
endmodule
bind sgoc_top sgoc_top_assertions chk_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .paddr_in(paddr_in), .pslverr_out(pslverr_out), .open_stat_in(open_stat_in),
    .close_stat_in(close_stat_in), .cart_in_stat_in(cart_in_stat_in), .cart_out_stat_in(cart_out_stat_in),
    .object_open_out(object_open_out), .object_close_out(object_close_out),
    .breaker_state_out(breaker_state_out), .cart_state_out(cart_state_out),
    .object_block_behaviour_view_out(object_block_behaviour_view_out));
`default_nettype wire

/* tb/sgoc_breaker_model.sv */
// Partner: breaker mechanism with travel time and spring recharge
`timescale 1ns/1ps
`default_nettype none
module sgoc_breaker_model #(
    parameter int TRAVEL = 8,
    parameter int RECHARGE = 300
) (
    input wire logic clk_in,
    input wire logic open_cmd_in,
    input wire logic close_cmd_in,
    // Forced contact levels
    input wire logic inj_en_in,
    input wire logic [1:0] inj_in,
    output logic open_stat_out,
    output logic close_stat_out,
    output logic ready_stat_out
);
    logic closed_q = 1'b0;
    logic tgt_q = 1'b0;
    int trav = 0;
    int charge = 0;
    // Both contacts drop while moving
    assign open_stat_out = inj_en_in ? inj_in[0] : (trav == 0 && !closed_q);
    assign close_stat_out = inj_en_in ? inj_in[1] : (trav == 0 && closed_q);
    assign ready_stat_out = (charge == 0);
    always @(posedge clk_in) begin
        if (charge > 0) charge <= charge - 1;
        if (trav > 1) trav <= trav - 1;
        else if (trav == 1) begin
            trav <= 0;
            closed_q <= tgt_q;
            if (tgt_q) charge <= RECHARGE;
        end else if (open_cmd_in && closed_q) begin
            trav <= TRAVEL;
            tgt_q <= 1'b0;
        end else if (close_cmd_in && !closed_q) begin
            trav <= TRAVEL;
            tgt_q <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* tb/sgoc_top_tb_top.sv */
// Testbench: object control block against a behavioural model
`timescale 1ns/1ps
`default_nettype none
module sgoc_top_tb_top;
    import sgoc_pkg::*;
    logic clk_in = 0, sys_rst_in = 1, psel = 0, penable = 0, pwrite = 0, pready, perr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rv, nm [8];
    logic [1:0] btn = 0, pnl = 0, aut = 0, inj = 0, cart = 0, bst;
    logic inj_en = 0, sync_s = 0, oo, oc, os, cs, rdy;
    logic [2:0] cst, view;
    logic [11:0] stat;
    int failures = 0, n_compared = 0, seen_q[$], run_w = 0, run_k = 0, i;
    int m_local = 0, m_moden = 0, m_fen = 0, m_mode = 0, m_rdy = 0, m_sync = 0, m_sbo = 0, m_sel = 0;
    int m_type = 1, m_single = 0, m_force = 0;
    sgoc_top dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(perr), .open_stat_in(os), .close_stat_in(cs), .cart_in_stat_in(cart[1]),
        .cart_out_stat_in(cart[0]), .ready_stat_in(rdy), .sync_stat_in(sync_s), .button_open_in(btn[0]),
        .button_close_in(btn[1]), .front_panel_open_in(pnl[0]), .front_panel_close_in(pnl[1]),
        .auto_open_in(aut[0]), .auto_close_in(aut[1]), .object_open_out(oo), .object_close_out(oc),
        .breaker_state_out(bst), .cart_state_out(cst), .object_block_behaviour_view_out(view), .status_out(stat));
    sgoc_breaker_model brk_u (.clk_in(clk_in), .open_cmd_in(oo), .close_cmd_in(oc), .inj_en_in(inj_en),
        .inj_in(inj), .open_stat_out(os), .close_stat_out(cs), .ready_stat_out(rdy));
    initial begin
        forever #2.5 clk_in = ~clk_in;
    end
    // Records kind and width of every contact pulse
    always @(negedge clk_in) begin
        if (oo === 1'b1 || oc === 1'b1) begin
            run_w++;
            run_k = (oo === 1'b1) ? 1 : 2;
        end else if (run_w != 0) begin
            seen_q.push_back(run_k * 100 + run_w);
            run_w = 0;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic e);
        @(posedge clk_in);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk_in);
        penable <= 1'b1;
        do begin
            @(posedge clk_in);
        end while (pready !== 1'b1);
        rv = prdata;
        e = perr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic e;
        apb(1'b1, a, d, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic e;
        apb(1'b0, a, 32'h0, e);
        chk(e, xe, "bus error");
        if (!xe) chk(rv, x, "read data");
    endtask
    task automatic setup();
        wr(SGOC_REG_CTRL, m_local | (m_fen << 1) | (m_moden << 2));
        wr(SGOC_REG_CONFIG, m_type | (m_sync << 2) | (m_rdy << 3) | (m_sbo << 5) | (m_single << 6)
            | (m_mode << 8) | (m_force << 12));
        repeat (6) @(negedge clk_in);
    endtask
    task automatic settle_chk();
        chk(bst, m_single ? (os ? SGOC_POS_OPEN : SGOC_POS_CLOSED) : {cs, os}, "position");
        chk(cst, m_type != 0 ? SGOC_CART_UNUSED : {1'b0, cart}, "cart");
        chk(view, m_moden ? m_mode : 0, "behaviour");
    endtask
    function automatic int expect_op(input int src, input int op);
        if (m_moden && m_mode != 0) return 0;
        if (src == 0 && (m_local || (m_sbo && !m_sel))) return 0;
        if ((src == 1 || src == 2) && !m_local) return 0;
        if (op == 2 && ((m_sync && !sync_s) || (m_rdy != 0 && rdy !== (m_rdy == 1)))) return 0;
        return op;
    endfunction
    task automatic issue(input int src, input int op);
        int e;
        e = expect_op(src, op);
        seen_q.delete();
        if (src == 0) begin
            m_sel = 0;
            wr(SGOC_REG_CMD, 32'h1 << (op - 1));
        end else begin
            @(posedge clk_in);
            case (src)
                1: btn[op-1] <= 1'b1;
                2: pnl[op-1] <= 1'b1;
                default: aut[op-1] <= 1'b1;
            endcase
            repeat (4) @(posedge clk_in);
            {btn, pnl, aut} <= 6'h0;
        end
        repeat (50) @(negedge clk_in);
        chk(seen_q.size(), e != 0, "pulse count");
        if (e != 0) chk(seen_q[0], e * 100 + SGOC_PULSE_CYC, "pulse kind and width");
        repeat (14) @(negedge clk_in);
        settle_chk();
    endtask
    task automatic report_and_stop();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #250000;
        failures++;
        report_and_stop();
    end
    initial begin
        rv = $urandom(32'h41d4);
        repeat (16) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        rd(SGOC_REG_CONFIG, SGOC_CFG_RESET, 1'b0);
        rd(SGOC_REG_CTRL, 32'h0, 1'b0);
        rd(SGOC_REG_END, 32'h0, 1'b1);
        rd(8'h06, 32'h0, 1'b1);
        settle_chk();
        for (i = 0; i < 8; i++) begin
            nm[i] = $urandom;
            wr(SGOC_REG_NAME + 8'(4 * i), nm[i]);
        end
        for (i = 0; i < 8; i++) rd(SGOC_REG_NAME + 8'(4 * i), nm[i], 1'b0);
        inj_en <= 1'b1;
        for (i = 0; i < 19; i++) begin
            m_type = i < 16 ? 0 : i - 15;
            m_single = (i ^ (i >> 2)) & 1;
            inj <= 2'(i);
            cart <= 2'(i >> 2);
            setup();
            settle_chk();
        end
        {inj_en, m_single, m_type} = 3'b001;
        cart <= 2'b00;
        setup();
        issue(0, 2);
        issue(1, 1);
        issue(2, 1);
        issue(3, 1);
        issue(0, 2);
        m_local = 1;
        setup();
        issue(0, 1);
        issue(1, 1);
        issue(2, 2);
        issue(3, 1);
        m_local = 0;
        setup();
        seen_q.delete();
        aut <= 2'b11;
        repeat (4) @(posedge clk_in);
        aut <= 2'b00;
        repeat (8) @(posedge clk_in);
        aut <= 2'b10;
        repeat (4) @(posedge clk_in);
        aut <= 2'b00;
        repeat (50) @(negedge clk_in);
        chk(seen_q.size(), 1, "simultaneous pulses");
        chk(seen_q[0], 100 + SGOC_PULSE_CYC, "open wins");
        m_sync = 1;
        setup();
        issue(0, 2);
        @(posedge clk_in) sync_s <= 1'b1;
        @(negedge clk_in);
        issue(0, 2);
        {m_sync, m_rdy} = 2'b01;
        setup();
        issue(0, 1);
        issue(0, 2);
        repeat (300) @(posedge clk_in);
        issue(0, 2);
        m_rdy = 2;
        setup();
        issue(0, 1);
        issue(0, 2);
        {m_rdy, m_sbo} = 2'b01;
        setup();
        issue(0, 1);
        wr(SGOC_REG_CMD, 32'h4);
        rd(SGOC_REG_CMD, 32'h1, 1'b0);
        m_sel = 1;
        issue(0, 1);
        wr(SGOC_REG_CMD, 32'h4);
        wr(SGOC_REG_CMD, 32'h8);
        rd(SGOC_REG_CMD, 32'h0, 1'b0);
        issue(0, 2);
        m_sbo = 0;
        m_moden = 1;
        for (i = 0; i < 5; i++) begin
            m_mode = i;
            setup();
            issue(0, bst === SGOC_POS_CLOSED ? 1 : 2);
        end
        {m_moden, m_mode} = 2'b01;
        setup();
        settle_chk();
        {m_mode, m_fen} = 2'b01;
        for (i = 1; i < SGOC_FORCE_COUNT; i++) begin
            m_force = i;
            setup();
            chk(stat[i-1], 1'b1, "forced status");
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
